/* File: pkg/vsf_pkg.sv */
// Purpose: Constants for the vertical-blanking slicer control registers
// Assumes: 8-bit register port, byte subaddresses
// Notes:   Offsets are byte subaddresses
package vsf_pkg;
	// Register offsets
	localparam logic [7:0] VSF_TTX_CTRL_ADR   = 8'hBB;
	localparam logic [7:0] VSF_WCOUNT_ADR     = 8'hBC;
	localparam logic [7:0] VSF_THRESH_ADR     = 8'hBD;
	localparam logic [7:0] VSF_FLUSH_ADR      = 8'hBF;
	localparam logic [7:0] VSF_ROUTE_ADR      = 8'hC0;
	localparam logic [7:0] VSF_LINE_INT_ADR   = 8'hC1;
	localparam logic [7:0] VSF_SWPOS_LO_ADR   = 8'hC2;
	localparam logic [7:0] VSF_SWPOS_HI_ADR   = 8'hC3;
	localparam logic [7:0] VSF_FIRST_LINE_ADR = 8'hD6;
	localparam logic [7:0] VSF_LAST_LINE_ADR  = 8'hD7;
	localparam logic [7:0] VSF_WIN_STD_ADR    = 8'hD8;
	localparam logic [7:0] VSF_FIFO_DATA_ADR  = 8'hE2;
	localparam logic [7:0] VSF_RAW_STAT_ADR   = 8'hF0;
	// Reset values
	localparam logic [7:0] VSF_TTX_CTRL_RST   = 8'h00;
	localparam logic [7:0] VSF_THRESH_RST     = 8'h80;
	localparam logic [0:0] VSF_ROUTE_RST      = 1'h0;
	localparam logic [7:0] VSF_LINE_INT_RST   = 8'h00;
	localparam logic [9:0] VSF_SWPOS_RST      = 10'h01E;
	localparam logic [7:0] VSF_FIRST_LINE_RST = 8'h06;
	localparam logic [7:0] VSF_LAST_LINE_RST  = 8'h1B;
	localparam logic [7:0] VSF_WIN_STD_RST    = 8'hFF;
	// Field positions
	localparam int VSF_F1_EN_BIT   = 0;
	localparam int VSF_F2_EN_BIT   = 1;
	localparam int VSF_MODE_BIT    = 2;
	localparam int VSF_LOGIC_LSB   = 3;
	localparam int VSF_FLD1_BIT    = 7;
	localparam int VSF_FLD2_BIT    = 6;
	localparam int VSF_THR_STAT_BIT  = 7;
	localparam int VSF_LINE_STAT_BIT = 0;
	localparam logic [7:0] VSF_TTX_CTRL_MASK = 8'h1F;
	localparam logic [5:0] VSF_MIN_LINE      = 6'h01;
	// Filter combine codes
	localparam logic [1:0] VSF_LOGIC_NOR  = 2'h0;
	localparam logic [1:0] VSF_LOGIC_NAND = 2'h1;
	localparam logic [1:0] VSF_LOGIC_OR   = 2'h2;
	localparam logic [1:0] VSF_LOGIC_AND  = 2'h3;
	// Header lengths
	localparam logic [2:0] VSF_HDR_SHORT = 3'h2;
	localparam logic [2:0] VSF_HDR_LONG  = 3'h5;
	// Slicing standard meaning no slicing
	localparam logic [7:0] VSF_STD_NONE = 8'hFF;
	// FIFO geometry
	localparam int         VSF_FIFO_AW    = 7;
	localparam logic [7:0] VSF_FIFO_DEPTH = 8'h80;
endpackage

/* File: rtl/vsf_regs.sv */
// Purpose: Control and status registers of the vertical-blanking slicer
// Assumes: Synchronous inputs, one clock, read data one cycle after strobe
// Notes:   Holds the sliced-data word store and its two drains
// Notes on behaviour
// - Filter decisions combine by code: 00 NOR, 01 NAND, 10 OR, 11 AND.
// - Mode bit 0 compares 2 header bytes, 1 compares 5 bytes.
// - Bit 0 enables filter 1, bit 1 filter 2, both off after reset.
// - Enabled filter true when masked data equals pattern, or mask all zero.
// - Word count register reads stored words, one word being two bytes.
// - Threshold flag raised while stored words exceed threshold, reset 80h.
// - Any write to flush empties store and clears data registers, self-clearing.
// - Routing bit 0 sends data to luma [9:2], 1 to host port.
// - Field enables bits 7 and 6; interrupt when line exceeds bits [5:0].
// - Programmed line zero or one never gives a line interrupt.
// - Per-line settings switch at 10-bit pixel position after sync fall.
// - Slicer acts on lines whose selected standard is not FFh, if between first and last line registers or while full-field mode is enabled.
// - Window standard applies to every window line without a per-line mode, reset FFh.
// - Per-line mode overrides window standard for that line.
// - Window standard overrides full-field mode inside the window.
// - Raw status: threshold in bit 7, line in bit 0.
// - Interrupt output is OR of raw bits ANDed with mask bits.
`timescale 1ns/1ps
module vsf_regs
	import vsf_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// Register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	// Teletext header bytes and filter settings
	input  wire logic        ttx_byte_valid_i,
	input  wire logic [2:0]  ttx_byte_index_i,
	input  wire logic [7:0]  ttx_byte_i,
	input  wire logic [19:0] ttx_f1_pattern_i,
	input  wire logic [19:0] ttx_f1_mask_i,
	input  wire logic [19:0] ttx_f2_pattern_i,
	input  wire logic [19:0] ttx_f2_mask_i,
	output logic             ttx_pass_o,
	output logic             ttx_pass_valid_o,
	// Sliced word input
	input  wire logic        fifo_wr_i,
	input  wire logic [15:0] fifo_wdata_i,
	output logic             fifo_wr_ready_o,
	// Luma output stream
	input  wire logic        luma_ready_i,
	output logic             luma_valid_o,
	output logic      [7:0]  luma_data_o,
	// Video timing
	input  wire logic        line_start_i,
	input  wire logic [9:0]  line_num_i,
	input  wire logic        field2_i,
	input  wire logic [9:0]  pixel_pos_i,
	// Per-line and full-field modes
	input  wire logic [7:0]  line_mode_i,
	input  wire logic        full_field_en_i,
	input  wire logic [7:0]  full_field_mode_i,
	// Slicing control
	output logic             slice_switch_o,
	output logic      [7:0]  slice_std_o,
	output logic             slice_active_o,
	// Data register clear and interrupt
	output logic             data_regs_clear_o,
	input  wire logic [7:0]  int_mask_i,
	output logic             int_o
);

	// Register file state
	logic [7:0]  ttx_ctrl_r, ttx_ctrl_nxt;
	logic [7:0]  thresh_r, thresh_nxt;
	logic        route_host_r, route_host_nxt;
	logic [7:0]  line_int_r, line_int_nxt;
	logic [9:0]  swpos_r, swpos_nxt;
	logic [7:0]  first_line_r, first_line_nxt;
	logic [7:0]  last_line_r, last_line_nxt;
	logic [7:0]  win_std_r, win_std_nxt;
	logic [7:0]  rdata_r, rdata_nxt;
	logic        clear_r, clear_nxt;

	// Word store state
	logic [15:0]            mem [0:VSF_FIFO_DEPTH-1];
	logic [VSF_FIFO_AW-1:0] wptr_r, wptr_nxt;
	logic [VSF_FIFO_AW-1:0] rptr_r, rptr_nxt;
	logic [7:0]             count_r, count_nxt;
	logic                   half_r, half_nxt;
	logic                   lv_r, lv_nxt;
	logic [7:0]             ld_r, ld_nxt;

	// Filter, line and slicing state
	logic        f1_ok_r, f1_ok_nxt;
	logic        f2_ok_r, f2_ok_nxt;
	logic        pass_r, pass_nxt;
	logic        pass_v_r, pass_v_nxt;
	logic        line_flag_r, line_flag_nxt;
	logic        sw_r, sw_nxt;
	logic [7:0]  std_r, std_nxt;
	logic        act_r, act_nxt;

	// Combinational helpers
	logic        push, pop, empty, full, flush;
	logic        byte_take, host_rd;
	logic [7:0]  cur_byte;
	logic [7:0]  raw_stat;
	logic [2:0]  hdr_len;
	logic        in_win;
	logic [7:0]  std_sel;

	// Filter test on one header byte: data bits 7,5,3,1 against a nibble
	function automatic logic nib_match(input logic [7:0] b, input logic [3:0] pat,
		input logic [3:0] msk);
		logic [3:0] d;
		d = {b[7], b[5], b[3], b[1]};
		nib_match = ((d ^ pat) & msk) == 4'h0;
	endfunction

	// Register match helper
	function automatic logic hit(input logic [7:0] a, input logic [7:0] adr);
		hit = a == adr;
	endfunction

	// Word store flags and transfers
	always_comb begin
		flush           = reg_wr_i && hit(reg_addr_i, VSF_FLUSH_ADR);
		empty           = count_r == 8'h00;
		full            = count_r == VSF_FIFO_DEPTH;
		fifo_wr_ready_o = !full && !flush;
		push            = fifo_wr_i && fifo_wr_ready_o;
		host_rd         = reg_rd_i && hit(reg_addr_i, VSF_FIFO_DATA_ADR);
		cur_byte        = half_r ? mem[rptr_r][15:8] : mem[rptr_r][7:0];
		byte_take       = !empty && (route_host_r ? host_rd
			: (!lv_r || luma_ready_i));
		pop             = byte_take && half_r;
	end

	always_comb begin
		wptr_nxt  = wptr_r;
		rptr_nxt  = rptr_r;
		count_nxt = count_r;
		half_nxt  = half_r;
		lv_nxt    = lv_r;
		ld_nxt    = ld_r;
		if (flush) begin
			wptr_nxt  = '0;
			rptr_nxt  = '0;
			count_nxt = 8'h00;
			half_nxt  = 1'b0;
			lv_nxt    = 1'b0;
		end else begin
			if (push)
				wptr_nxt = wptr_r + 1'b1;
			if (byte_take)
				half_nxt = !half_r;
			if (pop)
				rptr_nxt = rptr_r + 1'b1;
			count_nxt = count_r + {7'h00, push} - {7'h00, pop};
			if (!route_host_r && byte_take) begin
				lv_nxt = 1'b1;
				ld_nxt = cur_byte;
			end else if (luma_ready_i || route_host_r) begin
				lv_nxt = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk_i) begin
		if (push)
			mem[wptr_r] <= fifo_wdata_i;
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr_r  <= '0;
			rptr_r  <= '0;
			count_r <= 8'h00;
			half_r  <= 1'b0;
			lv_r    <= 1'b0;
			ld_r    <= 8'h00;
		end else begin
			wptr_r  <= wptr_nxt;
			rptr_r  <= rptr_nxt;
			count_r <= count_nxt;
			half_r  <= half_nxt;
			lv_r    <= lv_nxt;
			ld_r    <= ld_nxt;
		end
	end

	// Raw status and interrupt
	always_comb begin
		raw_stat = 8'h00;
		raw_stat[VSF_THR_STAT_BIT]  = count_r > thresh_r;
		raw_stat[VSF_LINE_STAT_BIT] = line_flag_r;
	end

	// Register writes and reads
	always_comb begin
		ttx_ctrl_nxt   = ttx_ctrl_r;
		thresh_nxt     = thresh_r;
		route_host_nxt = route_host_r;
		line_int_nxt   = line_int_r;
		swpos_nxt      = swpos_r;
		first_line_nxt = first_line_r;
		last_line_nxt  = last_line_r;
		win_std_nxt    = win_std_r;
		clear_nxt      = flush;
		rdata_nxt      = rdata_r;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				VSF_TTX_CTRL_ADR:   ttx_ctrl_nxt   = reg_wdata_i & VSF_TTX_CTRL_MASK;
				VSF_THRESH_ADR:     thresh_nxt     = reg_wdata_i;
				VSF_ROUTE_ADR:      route_host_nxt = reg_wdata_i[0];
				VSF_LINE_INT_ADR:   line_int_nxt   = reg_wdata_i;
				VSF_SWPOS_LO_ADR:   swpos_nxt      = {swpos_r[9:8], reg_wdata_i};
				VSF_SWPOS_HI_ADR:   swpos_nxt      = {reg_wdata_i[1:0], swpos_r[7:0]};
				VSF_FIRST_LINE_ADR: first_line_nxt = reg_wdata_i;
				VSF_LAST_LINE_ADR:  last_line_nxt  = reg_wdata_i;
				VSF_WIN_STD_ADR:    win_std_nxt    = reg_wdata_i;
				default:            ;
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				VSF_TTX_CTRL_ADR:   rdata_nxt = ttx_ctrl_r;
				VSF_WCOUNT_ADR:     rdata_nxt = count_r;
				VSF_THRESH_ADR:     rdata_nxt = thresh_r;
				VSF_ROUTE_ADR:      rdata_nxt = {7'h00, route_host_r};
				VSF_LINE_INT_ADR:   rdata_nxt = line_int_r;
				VSF_SWPOS_LO_ADR:   rdata_nxt = swpos_r[7:0];
				VSF_SWPOS_HI_ADR:   rdata_nxt = {6'h00, swpos_r[9:8]};
				VSF_FIRST_LINE_ADR: rdata_nxt = first_line_r;
				VSF_LAST_LINE_ADR:  rdata_nxt = last_line_r;
				VSF_WIN_STD_ADR:    rdata_nxt = win_std_r;
				VSF_FIFO_DATA_ADR:  rdata_nxt = (route_host_r && byte_take) ? cur_byte : 8'h00;
				VSF_RAW_STAT_ADR:   rdata_nxt = raw_stat;
				default:            rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ttx_ctrl_r   <= VSF_TTX_CTRL_RST;
			thresh_r     <= VSF_THRESH_RST;
			route_host_r <= VSF_ROUTE_RST;
			line_int_r   <= VSF_LINE_INT_RST;
			swpos_r      <= VSF_SWPOS_RST;
			first_line_r <= VSF_FIRST_LINE_RST;
			last_line_r  <= VSF_LAST_LINE_RST;
			win_std_r    <= VSF_WIN_STD_RST;
			clear_r      <= 1'b0;
			rdata_r      <= 8'h00;
		end else begin
			ttx_ctrl_r   <= ttx_ctrl_nxt;
			thresh_r     <= thresh_nxt;
			route_host_r <= route_host_nxt;
			line_int_r   <= line_int_nxt;
			swpos_r      <= swpos_nxt;
			first_line_r <= first_line_nxt;
			last_line_r  <= last_line_nxt;
			win_std_r    <= win_std_nxt;
			clear_r      <= clear_nxt;
			rdata_r      <= rdata_nxt;
		end
	end

	// Teletext header filtering
	always_comb begin
		hdr_len    = ttx_ctrl_r[VSF_MODE_BIT] ? VSF_HDR_LONG : VSF_HDR_SHORT;
		f1_ok_nxt  = f1_ok_r;
		f2_ok_nxt  = f2_ok_r;
		pass_nxt   = pass_r;
		pass_v_nxt = 1'b0;
		if (ttx_byte_valid_i && ttx_byte_index_i < hdr_len) begin
			// First byte restarts both accumulations
			f1_ok_nxt = (ttx_byte_index_i == 3'h0 || f1_ok_r)
				&& nib_match(ttx_byte_i, ttx_f1_pattern_i[ttx_byte_index_i*4 +: 4],
					ttx_f1_mask_i[ttx_byte_index_i*4 +: 4]);
			f2_ok_nxt = (ttx_byte_index_i == 3'h0 || f2_ok_r)
				&& nib_match(ttx_byte_i, ttx_f2_pattern_i[ttx_byte_index_i*4 +: 4],
					ttx_f2_mask_i[ttx_byte_index_i*4 +: 4]);
			if (ttx_byte_index_i == hdr_len - 3'h1) begin
				pass_v_nxt = 1'b1;
				f1_ok_nxt  = f1_ok_nxt && ttx_ctrl_r[VSF_F1_EN_BIT];
				f2_ok_nxt  = f2_ok_nxt && ttx_ctrl_r[VSF_F2_EN_BIT];
				unique case (ttx_ctrl_r[VSF_LOGIC_LSB +: 2])
					VSF_LOGIC_NOR:  pass_nxt = !(f1_ok_nxt || f2_ok_nxt);
					VSF_LOGIC_NAND: pass_nxt = !(f1_ok_nxt && f2_ok_nxt);
					VSF_LOGIC_OR:   pass_nxt = f1_ok_nxt || f2_ok_nxt;
					VSF_LOGIC_AND:  pass_nxt = f1_ok_nxt && f2_ok_nxt;
				endcase
			end
		end
	end

	// Line interrupt and slicing standard selection
	always_comb begin
		line_flag_nxt = line_flag_r;
		if (line_start_i)
			line_flag_nxt = line_int_r[5:0] > VSF_MIN_LINE
				&& line_num_i > {4'h0, line_int_r[5:0]}
				&& (field2_i ? line_int_r[VSF_FLD2_BIT] : line_int_r[VSF_FLD1_BIT]);
		in_win = line_num_i >= {2'h0, first_line_r}
			&& line_num_i <= {2'h0, last_line_r};
		if (line_mode_i != VSF_STD_NONE)
			std_sel = line_mode_i;
		else if (in_win)
			std_sel = win_std_r;
		else if (full_field_en_i)
			std_sel = full_field_mode_i;
		else
			std_sel = VSF_STD_NONE;
		sw_nxt  = pixel_pos_i == swpos_r;
		std_nxt = std_r;
		act_nxt = act_r;
		if (sw_nxt) begin
			std_nxt = std_sel;
			act_nxt = std_sel != VSF_STD_NONE && (in_win || full_field_en_i);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			f1_ok_r     <= 1'b0;
			f2_ok_r     <= 1'b0;
			pass_r      <= 1'b0;
			pass_v_r    <= 1'b0;
			line_flag_r <= 1'b0;
			sw_r        <= 1'b0;
			std_r       <= VSF_STD_NONE;
			act_r       <= 1'b0;
		end else begin
			f1_ok_r     <= f1_ok_nxt;
			f2_ok_r     <= f2_ok_nxt;
			pass_r      <= pass_nxt;
			pass_v_r    <= pass_v_nxt;
			line_flag_r <= line_flag_nxt;
			sw_r        <= sw_nxt;
			std_r       <= std_nxt;
			act_r       <= act_nxt;
		end
	end

	// Outputs
	assign reg_rdata_o       = rdata_r;
	assign ttx_pass_o        = pass_r;
	assign ttx_pass_valid_o  = pass_v_r;
	assign luma_valid_o      = lv_r;
	assign luma_data_o       = ld_r;
	assign slice_switch_o    = sw_r;
	assign slice_std_o       = std_r;
	assign slice_active_o    = act_r;
	assign data_regs_clear_o = clear_r;
	assign int_o             = |(raw_stat & int_mask_i);

endmodule

/* File: testbench/vsf_regs_monitor.sv */
// Purpose: Port-level checks on the slicer register block
// Assumes: One clock, async active-high reset
// Notes:   Bound to vsf_regs
`timescale 1ns/1ps
module vsf_regs_monitor
	import vsf_pkg::*;
(
	// Clock and reset
	input wire logic       mclk_i,
	input wire logic       rst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Data path and status
	input wire logic       ttx_byte_valid_i,
	input wire logic       ttx_pass_valid_o,
	input wire logic       fifo_wr_ready_o,
	input wire logic       luma_ready_i,
	input wire logic       luma_valid_o,
	input wire logic [7:0] luma_data_o,
	input wire logic       data_regs_clear_o,
	input wire logic [7:0] int_mask_i,
	input wire logic       int_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	logic host_r;
	logic host_nxt;
	// Shadow of the routing bit
	always_comb begin
		host_nxt = host_r;
		if (reg_wr_i && reg_addr_i == VSF_ROUTE_ADR) begin
			host_nxt = reg_wdata_i[0];
		end
	end
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			host_r <= VSF_ROUTE_RST;
		end else begin
			host_r <= host_nxt;
		end
	end
	sequence flush_s;
		reg_wr_i && reg_addr_i == VSF_FLUSH_ADR;
	endsequence
	flush_pulse_a: assert property (flush_s |=> data_regs_clear_o)
		else $error("flush gave no clear pulse");
	clear_cause_a: assert property (data_regs_clear_o |->
		$past(reg_wr_i && reg_addr_i == VSF_FLUSH_ADR))
		else $error("clear pulse without flush");
	flush_block_a: assert property (flush_s |-> !fifo_wr_ready_o)
		else $error("push accepted during flush");
	flush_idle_a: assert property (flush_s |=> !luma_valid_o)
		else $error("luma busy after flush");
	flush_read_a: assert property (reg_rd_i && reg_addr_i == VSF_FLUSH_ADR |=>
		reg_rdata_o == 8'h00)
		else $error("flush register read nonzero");
	unmapped_read_a: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
		reg_rdata_o == 8'h00)
		else $error("unmapped read nonzero");
	mask_off_a: assert property (int_mask_i == 8'h00 |-> !int_o)
		else $error("interrupt with all masked");
	host_quiet_a: assert property (host_r && $past(host_r) |-> !luma_valid_o)
		else $error("luma active in host route");
	luma_hold_a: assert property (luma_valid_o && !luma_ready_i
		&& !(reg_wr_i && reg_addr_i == VSF_FLUSH_ADR)
		|=> luma_valid_o && $stable(luma_data_o))
		else $error("luma byte dropped on stall");
	ttx_valid_a: assert property (ttx_pass_valid_o |-> $past(ttx_byte_valid_i))
		else $error("decision without header byte");
endmodule
bind vsf_regs vsf_regs_monitor u_mon (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
	.reg_rd_i, .reg_rdata_o, .ttx_byte_valid_i, .ttx_pass_valid_o, .fifo_wr_ready_o,
	.luma_ready_i, .luma_valid_o, .luma_data_o, .data_regs_clear_o, .int_mask_i, .int_o);

/* File: testbench/testbench.sv */
// Purpose: Self-checking bench for the slicer register block
// Assumes: Queue model of the word store
// Notes:   Filter 2 compares the first header byte, filter 1 the last
`timescale 1ns/1ps
module testbench import vsf_pkg::*; ;
	logic        mclk_i, rst_i, reg_wr_i, reg_rd_i, ttx_byte_valid_i, fifo_wr_i, luma_ready_i;
	logic        line_start_i, field2_i, full_field_en_i, ttx_pass_o, ttx_pass_valid_o;
	logic        fifo_wr_ready_o, luma_valid_o, slice_switch_o, slice_active_o;
	logic        data_regs_clear_o, int_o, d1, d2, ex;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, ttx_byte_i, line_mode_i, b;
	logic [7:0]  full_field_mode_i, int_mask_i, luma_data_o, slice_std_o, h;
	logic [2:0]  ttx_byte_index_i;
	logic [19:0] ttx_f1_pattern_i, ttx_f1_mask_i, ttx_f2_pattern_i, ttx_f2_mask_i;
	logic [15:0] fifo_wdata_i;
	logic [9:0]  line_num_i, pixel_pos_i;
	logic [7:0]  q[$];
	int          num_errors, cmp_count, i, j, k, t;
	logic [7:0]  ra[12] = '{8'hBB, 8'hBC, 8'hBD, 8'hBF, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hD6,
		8'hD7, 8'hD8, 8'h00};
	logic [7:0]  rv[12] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h1E, 8'h00, 8'h06,
		8'h1B, 8'hFF, 8'h00};
	logic [7:0]  rm[12] = '{8'h1F, 8'h00, 8'hFF, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'h03, 8'hFF,
		8'hFF, 8'hFF, 8'h00};
	vsf_regs u_dut (.mclk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .ttx_byte_valid_i, .ttx_byte_index_i, .ttx_byte_i, .ttx_f1_pattern_i,
		.ttx_f1_mask_i, .ttx_f2_pattern_i, .ttx_f2_mask_i, .ttx_pass_o,
		.ttx_pass_valid_o, .fifo_wr_i, .fifo_wdata_i, .fifo_wr_ready_o, .luma_ready_i,
		.luma_valid_o, .luma_data_o, .line_start_i, .line_num_i, .field2_i, .pixel_pos_i,
		.line_mode_i, .full_field_en_i, .full_field_mode_i, .slice_switch_o, .slice_std_o,
		.slice_active_o, .data_regs_clear_o, .int_mask_i, .int_o);
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		#1 chk($sformatf("reg %h", a), e, reg_rdata_o);
	endtask
	task automatic push(input logic [15:0] w);
		@(posedge mclk_i);
		fifo_wr_i <= 1'b1;
		fifo_wdata_i <= w;
		@(posedge mclk_i);
		fifo_wr_i <= 1'b0;
		q.push_back(w[7:0]);
		q.push_back(w[15:8]);
	endtask
	task automatic li(input logic [7:0] c, input logic [9:0] n, input logic f, input logic [7:0] e);
		wr(VSF_LINE_INT_ADR, c);
		@(posedge mclk_i);
		line_start_i <= 1'b1;
		line_num_i <= n;
		field2_i <= f;
		@(posedge mclk_i);
		line_start_i <= 1'b0;
		rc(VSF_RAW_STAT_ADR, e);
	endtask
	task automatic sl(input logic [9:0] n, input logic [7:0] lm, input logic fe,
		input logic [7:0] fm, input logic [7:0] es, input logic ea);
		@(posedge mclk_i);
		line_start_i <= 1'b1;
		line_num_i <= n;
		line_mode_i <= lm;
		full_field_en_i <= fe;
		full_field_mode_i <= fm;
		@(posedge mclk_i);
		line_start_i <= 1'b0;
		pixel_pos_i <= 10'h01E;
		@(posedge mclk_i);
		pixel_pos_i <= 10'h01F;
		#1 chk("switch", 8'h01, {7'h00, slice_switch_o});
		chk("std", es, slice_std_o);
		chk("active", {7'h00, ea}, {7'h00, slice_active_o});
	endtask
	task automatic end_sim;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk_i) begin
		luma_ready_i <= 1'($urandom);
		if (!rst_i && luma_valid_o && luma_ready_i) begin
			chk("luma", q.pop_front(), luma_data_o);
		end
	end
	initial begin
		#200000;
		num_errors++;
		end_sim();
	end
	initial begin
		{reg_wr_i, reg_rd_i, ttx_byte_valid_i, fifo_wr_i, line_start_i, field2_i} = 6'h00;
		{reg_addr_i, reg_wdata_i, ttx_byte_i, full_field_mode_i, int_mask_i} = 40'h0;
		{ttx_byte_index_i, ttx_f1_pattern_i, ttx_f1_mask_i, fifo_wdata_i} = 59'h0;
		{ttx_f2_pattern_i, ttx_f2_mask_i} = 40'h0;
		{line_num_i, pixel_pos_i, full_field_en_i} = 21'h0;
		line_mode_i = 8'hFF;
		luma_ready_i = 1'b0;
		rst_i = 1'b1;
		void'($urandom(32'h57BA6A15));
		repeat (4) @(posedge mclk_i);
		rst_i <= 1'b0;
		foreach (ra[k]) rc(ra[k], rv[k]);
		foreach (ra[k]) begin
			b = 8'($urandom);
			wr(ra[k], b);
			rc(ra[k], b & rm[k]);
		end
		wr(VSF_SWPOS_LO_ADR, 8'h1E);
		wr(VSF_SWPOS_HI_ADR, 8'h00);
		wr(VSF_ROUTE_ADR, 8'h01);
		repeat (5) push(16'($urandom));
		rc(VSF_WCOUNT_ADR, 8'h05);
		wr(VSF_THRESH_ADR, 8'h04);
		rc(VSF_RAW_STAT_ADR, 8'h80);
		int_mask_i <= 8'h80;
		#41 chk("int", 8'h01, {7'h00, int_o});
		int_mask_i <= 8'h7F;
		#40 chk("int", 8'h00, {7'h00, int_o});
		wr(VSF_THRESH_ADR, 8'h05);
		rc(VSF_RAW_STAT_ADR, 8'h00);
		int_mask_i <= 8'h00;
		for (i = 0; i < 10; i++) rc(VSF_FIFO_DATA_ADR, q.pop_front());
		rc(VSF_WCOUNT_ADR, 8'h00);
		repeat (3) push(16'($urandom));
		wr(VSF_FLUSH_ADR, 8'($urandom));
		q.delete();
		rc(VSF_WCOUNT_ADR, 8'h00);
		rc(VSF_FIFO_DATA_ADR, 8'h00);
		wr(VSF_ROUTE_ADR, 8'h00);
		repeat (6) push(16'($urandom));
		repeat (60) @(posedge mclk_i);
		chk("left", 8'h00, 8'(q.size()));
		li(8'h85, 10'd6, 1'b0, 8'h01);
		li(8'h85, 10'd5, 1'b0, 8'h00);
		li(8'h85, 10'd6, 1'b1, 8'h00);
		li(8'h42, 10'd3, 1'b1, 8'h01);
		li(8'hC1, 10'd40, 1'b1, 8'h00);
		li(8'hC0, 10'd40, 1'b0, 8'h00);
		for (i = 0; i < 16; i++) begin
			b = 8'($urandom);
			k = i[2] ? 4 : 1;
			d1 = i[3];
			d2 = i[3] ^ i[2];
			ex = i[1] ? (i[0] ? d1 & d2 : d1 | d2) : (i[0] ? !(d1 & d2) : !(d1 | d2));
			ttx_f1_mask_i <= 20'hF << (4 * k);
			ttx_f1_pattern_i <= 20'({b[7], b[5], b[3], b[1] ^ !d1}) << (4 * k);
			h = 8'($urandom);
			ttx_f2_mask_i <= 20'h0000F;
			ttx_f2_pattern_i <= 20'({h[7], h[5], h[3], h[1] ^ !d2});
			wr(VSF_TTX_CTRL_ADR, {3'h0, 2'(i), i[2], d2 | i[0], 1'b1});
			for (j = 0; j <= k; j++) begin
				@(posedge mclk_i);
				ttx_byte_valid_i <= 1'b1;
				ttx_byte_index_i <= 3'(j);
				ttx_byte_i <= (j == k) ? b : ((j == 0) ? h : 8'($urandom));
			end
			@(posedge mclk_i);
			ttx_byte_valid_i <= 1'b0;
			#1 t = 0;
			while (ttx_pass_valid_o !== 1'b1 && t < 8) begin
				@(posedge mclk_i);
				#1 t++;
			end
			chk("ttx", {7'h00, ex}, {7'h00, ttx_pass_o});
		end
		wr(VSF_FIRST_LINE_ADR, 8'h06);
		wr(VSF_LAST_LINE_ADR, 8'h1B);
		wr(VSF_WIN_STD_ADR, 8'h03);
		sl(10'd10, 8'hFF, 1'b0, 8'h00, 8'h03, 1'b1);
		sl(10'd6, 8'hFF, 1'b0, 8'h00, 8'h03, 1'b1);
		sl(10'd27, 8'hFF, 1'b0, 8'h00, 8'h03, 1'b1);
		sl(10'd30, 8'hFF, 1'b0, 8'h00, 8'hFF, 1'b0);
		sl(10'd10, 8'h05, 1'b0, 8'h00, 8'h05, 1'b1);
		sl(10'd10, 8'hFF, 1'b1, 8'h07, 8'h03, 1'b1);
		sl(10'd30, 8'hFF, 1'b1, 8'h07, 8'h07, 1'b1);
		end_sim();
	end
endmodule
